/* File: include/dsf_consts.svh */
// Sector layout, sizes and control bit positions of the sector formatter.
// Included by the formatter modules; holds definitions only.
`ifndef DSF_CONSTS_SVH
`define DSF_CONSTS_SVH
`define DSF_POSTAMBLE_BYTES 4
`define DSF_PREAMBLE_BYTES 13
`define DSF_SYNC_BYTES 1
`define DSF_HEADER_BYTES 4
`define DSF_CHECK_BYTES 4
`define DSF_TRAIL_BYTES 2
`define DSF_DATA_BYTES 512
`define DSF_FIELD_BYTES 556
`define DSF_RECOVERY_MIN 10
`define DSF_MIN_SECTOR 570
`define DSF_MIN_SECTOR_REMOVABLE 574
`define DSF_SECTOR_BYTES 576
`define DSF_SECTORS_PER_TRACK 35
`define DSF_INTERLEAVE 3
`define DSF_MAX_UNITS 8
`define DSF_UNITS_DRIVE0 4
`define DSF_UNITS_DRIVE1 4
`define DSF_UNIT_SPAN 100
`define DSF_HEADS 19
`define DSF_LOGICAL_HEADS 20
// Sync pattern and check polynomials are arbitrary defaults
`define DSF_SYNC_PATTERN 8'h5E
`define DSF_CRC_POLY 32'h00A00805
`define DSF_ECC_POLY 32'h40A00B05
`define DSF_CHECK_SEED 32'h00000000
`define DSF_CB_WRITE_GATE 0
`define DSF_CB_READ_GATE 1
`define DSF_CB_ADDRESS_MARK_ENABLE 5
`endif

/* File: include/dsf_pkg.sv */
// Types shared by the sector formatter modules.
// Assumes nothing beyond a SystemVerilog compiler.
package dsf_pkg;
  typedef enum logic [3:0] {
    DSF_IDLE, DSF_WAIT, DSF_POST, DSF_HPRE, DSF_HSYNC, DSF_HDR, DSF_HCHK,
    DSF_HTRL, DSF_DPRE, DSF_DSYNC, DSF_DATA, DSF_DCHK, DSF_DTRL, DSF_RECOV
  } dsf_phase_type;
  typedef struct packed {
    logic [2:0] unit;
    logic [15:0] cylinder;
    logic [7:0] track;
    logic [7:0] sector;
  } dsf_addr_type;
  typedef struct packed {
    logic servo_clock;
    logic read_clock;
    logic read_data;
    logic sector_pulse;
    logic index_pulse;
  } dsf_drive_in_type;
  typedef struct packed {
    logic write_data;
    logic write_clock;
    logic control_tag;
    logic [9:0] control_bit;
    logic drive_select;
  } dsf_drive_out_type;
  typedef struct packed {
    logic busy;
    logic done;
    logic unit_error;
    logic header_crc_error;
    logic header_mismatch;
    logic data_check;
    logic correction_request;
    logic sector_overrun;
  } dsf_status_type;
  typedef struct packed {
    logic [15:0] cylinder;
    logic [7:0] head;
    logic drive;
  } dsf_phys_type;
  typedef struct packed {
    logic [7:0] tx_shift;
    logic [2:0] tx_count;
    logic tx_bit;
    logic tx_take;
    logic [7:0] rx_shift;
    logic [2:0] rx_count;
    logic framed;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic sync_found;
  } dsf_serdes_state_type;
  typedef struct packed {
    logic [31:0] value;
  } dsf_check_state_type;
  typedef struct packed {
    dsf_drive_in_type sync1;
    dsf_drive_in_type sync2;
    dsf_drive_in_type last;
    dsf_phase_type phase;
    logic writing;
    logic [9:0] count;
    logic [7:0] sector_count;
    logic [7:0] target;
    dsf_addr_type addr;
    dsf_phys_type phys;
    logic [7:0] cur_byte;
    logic [31:0] snap;
    logic [7:0] pend;
    logic pend_full;
    logic fill;
    logic [9:0] took;
    logic [31:0] rx_header;
    dsf_drive_out_type drive;
    dsf_status_type status;
    logic cmd_ready;
    logic wr_ready;
    logic [7:0] rd_data;
    logic rd_valid;
  } dsf_top_state_type;
endpackage : dsf_pkg

/* File: logic/dsf_check.sv */
// Shared 32-bit check register: header cyclic check or data-field code.
// Assumes byte strobes from the formatter on the same clock.
`include "dsf_consts.svh"
module dsf_check #(
  parameter logic [31:0] CRC_POLY = `DSF_CRC_POLY,
  parameter logic [31:0] ECC_POLY = `DSF_ECC_POLY,
  parameter logic [31:0] SEED = `DSF_CHECK_SEED
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Byte feed
  input wire logic clear,
  input wire logic ecc_mode,
  input wire logic en,
  input wire logic [7:0] data_byte,
  // Remainder, zero after a clean field plus its check bytes
  output logic [31:0] value
);
  dsf_pkg::dsf_check_state_type s;
  dsf_pkg::dsf_check_state_type n;

  function automatic logic [31:0] step(input logic [31:0] r, input logic [7:0] d,
                                       input logic [31:0] p);
    logic [31:0] t;
    logic fb;
    t = r;
    for (int i = 7; i >= 0; i--) begin
      fb = t[31] ^ d[i];
      t = {t[30:0], 1'b0} ^ (fb ? p : 32'h00000000);
    end
    return t;
  endfunction : step

  always_comb begin
    n = s;
    if (clear) begin
      n.value = SEED;
    end else if (en) begin
      n.value = step(s.value, data_byte, ecc_mode ? ECC_POLY : CRC_POLY);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign value = s.value;
endmodule : dsf_check

/* File: logic/dsf_formatter.sv */
// Disk sector formatter/deformatter: writes and reads one sector per command.
// Drive cable inputs are asynchronous; the command side is on clk.
`include "dsf_consts.svh"
module dsf_formatter #(
  parameter int SECTOR_BYTES = `DSF_SECTOR_BYTES,
  parameter int SECTORS_PER_TRACK = `DSF_SECTORS_PER_TRACK,
  parameter bit REMOVABLE = 1'b1,
  parameter int POSTAMBLE_BYTES = `DSF_POSTAMBLE_BYTES,
  parameter bit MAP_BY_TRACKS = 1'b0,
  parameter int UNITS_DRIVE0 = `DSF_UNITS_DRIVE0,
  parameter int UNITS_DRIVE1 = `DSF_UNITS_DRIVE1,
  parameter int UNIT_SPAN = `DSF_UNIT_SPAN,
  parameter int HEADS = `DSF_HEADS,
  parameter int LOGICAL_HEADS = `DSF_LOGICAL_HEADS,
  parameter logic [7:0] SYNC_PATTERN = `DSF_SYNC_PATTERN,
  parameter logic [31:0] CRC_POLY = `DSF_CRC_POLY,
  parameter logic [31:0] ECC_POLY = `DSF_ECC_POLY
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Command
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire dsf_pkg::dsf_addr_type cmd_addr,
  input wire logic [9:0] drive_command,
  output dsf_pkg::dsf_addr_type cmd_ready_unused_guard,
  output logic cmd_ready,
  output dsf_pkg::dsf_phys_type phys,
  output dsf_pkg::dsf_status_type status,
  // Sector data
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Drive cables
  input wire dsf_pkg::dsf_drive_in_type drive_in,
  output dsf_pkg::dsf_drive_out_type drive_out
);
  // Sector geometry, clamped so a bad parameter cannot break the layout
  localparam int MIN_LEN = REMOVABLE ? `DSF_MIN_SECTOR_REMOVABLE : `DSF_MIN_SECTOR;
  localparam int SECT_LEN = (SECTOR_BYTES < MIN_LEN) ? MIN_LEN : SECTOR_BYTES;
  localparam int POST = (POSTAMBLE_BYTES < `DSF_POSTAMBLE_BYTES) ?
                        `DSF_POSTAMBLE_BYTES : POSTAMBLE_BYTES;
  localparam int RECOV0 = SECT_LEN - POST - `DSF_FIELD_BYTES;
  localparam int RECOV = (RECOV0 < `DSF_RECOVERY_MIN) ? `DSF_RECOVERY_MIN : RECOV0;
  localparam int U0 = (UNITS_DRIVE0 < 1) ? 1 : (UNITS_DRIVE0 > 8) ? 8 : UNITS_DRIVE0;
  localparam int U1R = `DSF_MAX_UNITS - U0;
  localparam int U1 = (UNITS_DRIVE1 > U1R) ? U1R : UNITS_DRIVE1;

  dsf_pkg::dsf_top_state_type s;
  dsf_pkg::dsf_top_state_type n;
  logic servo_rise;
  logic read_rise;
  logic sector_rise;
  logic index_rise;
  logic tx_bit;
  logic tx_take;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic sync_found;
  logic rx_hunt;
  logic chk_clear;
  logic chk_en;
  logic chk_mode;
  logic [7:0] chk_byte;
  logic [31:0] check;
  logic [9:0] c1;
  logic [7:0] b;

  function automatic logic [9:0] region_len(input dsf_pkg::dsf_phase_type p);
    unique case (p)
      dsf_pkg::DSF_POST: return 10'(POST);
      dsf_pkg::DSF_HPRE, dsf_pkg::DSF_DPRE: return 10'(`DSF_PREAMBLE_BYTES);
      dsf_pkg::DSF_HDR: return 10'(`DSF_HEADER_BYTES);
      dsf_pkg::DSF_HCHK, dsf_pkg::DSF_DCHK: return 10'(`DSF_CHECK_BYTES);
      dsf_pkg::DSF_HTRL, dsf_pkg::DSF_DTRL: return 10'(`DSF_TRAIL_BYTES);
      dsf_pkg::DSF_DATA: return 10'(`DSF_DATA_BYTES);
      dsf_pkg::DSF_RECOV: return 10'(RECOV);
      default: return 10'(`DSF_SYNC_BYTES);
    endcase
  endfunction : region_len

  function automatic dsf_pkg::dsf_phase_type next_phase(input dsf_pkg::dsf_phase_type p);
    return dsf_pkg::dsf_phase_type'(4'(p) + 4'h1);
  endfunction : next_phase

  // Header bytes go out high byte first: cylinder, then track, then sector
  function automatic logic [7:0] hdr_byte(input dsf_pkg::dsf_addr_type a,
                                          input logic [1:0] i);
    unique case (i)
      2'h0: return a.cylinder[15:8];
      2'h1: return a.cylinder[7:0];
      2'h2: return a.track;
      default: return a.sector;
    endcase
  endfunction : hdr_byte

  // Spread logical sectors three apart; shift each wrap when the count divides
  function automatic logic [7:0] interleave(input logic [7:0] l);
    int t;
    t = int'(l) * `DSF_INTERLEAVE;
    return 8'(t % SECTORS_PER_TRACK +
              ((SECTORS_PER_TRACK % `DSF_INTERLEAVE == 0) ? t / SECTORS_PER_TRACK : 0));
  endfunction : interleave

  function automatic dsf_pkg::dsf_phys_type map_unit(input dsf_pkg::dsf_addr_type a);
    dsf_pkg::dsf_phys_type p;
    int lu;
    int lin;
    p.drive = (int'(a.unit) >= U0);
    lu = p.drive ? int'(a.unit) - U0 : int'(a.unit);
    if (MAP_BY_TRACKS) begin
      lin = lu * UNIT_SPAN + int'(a.cylinder) * LOGICAL_HEADS + int'(a.track);
      p.cylinder = 16'(lin / HEADS);
      p.head = 8'(lin % HEADS);
    end else begin
      p.cylinder = 16'(lu * UNIT_SPAN + int'(a.cylinder));
      p.head = a.track;
    end
    return p;
  endfunction : map_unit

  function automatic dsf_pkg::dsf_top_state_type finish(input dsf_pkg::dsf_top_state_type t);
    dsf_pkg::dsf_top_state_type r;
    r = t;
    r.phase = dsf_pkg::DSF_IDLE;
    r.writing = 1'b0;
    r.drive.control_bit[`DSF_CB_WRITE_GATE] = 1'b0;
    r.drive.control_bit[`DSF_CB_READ_GATE] = 1'b0;
    r.status.done = 1'b1;
    r.pend_full = 1'b0;
    return r;
  endfunction : finish

  // Edges of the synchronised drive signals; first stage is never read here
  assign servo_rise = s.sync2.servo_clock & ~s.last.servo_clock;
  assign read_rise = s.sync2.read_clock & ~s.last.read_clock;
  assign sector_rise = s.sync2.sector_pulse & ~s.last.sector_pulse;
  assign index_rise = s.sync2.index_pulse & ~s.last.index_pulse;
  assign rx_hunt = !s.writing &&
                   (s.phase == dsf_pkg::DSF_HSYNC || s.phase == dsf_pkg::DSF_DSYNC);

  dsf_serdes #(
    .SYNC_PATTERN(SYNC_PATTERN)
  ) u_serdes (
    .clk(clk),
    .resetn(resetn),
    .tx_tick(servo_rise),
    .tx_byte(s.cur_byte),
    .tx_bit(tx_bit),
    .tx_take(tx_take),
    .rx_tick(read_rise),
    .rx_bit(s.sync2.read_data),
    .rx_hunt(rx_hunt),
    .rx_byte(rx_byte),
    .rx_valid(rx_valid),
    .sync_found(sync_found)
  );

  dsf_check #(
    .CRC_POLY(CRC_POLY),
    .ECC_POLY(ECC_POLY),
    .SEED(`DSF_CHECK_SEED)
  ) u_check (
    .clk(clk),
    .resetn(resetn),
    .clear(chk_clear),
    .ecc_mode(chk_mode),
    .en(chk_en),
    .data_byte(chk_byte),
    .value(check)
  );

  always_comb begin
    n = s;
    chk_clear = 1'b0;
    chk_en = 1'b0;
    chk_byte = 8'h00;
    b = 8'h00;
    c1 = s.count + 10'h001;
    n.sync1 = drive_in;
    n.sync2 = s.sync1;
    n.last = s.sync2;
    n.status.done = 1'b0;
    n.status.correction_request = 1'b0;
    n.rd_valid = 1'b0;
    // A runt sector without a pulse is the one index opens, and it counts as sector 0
    if (index_rise) begin
      n.sector_count = 8'h00;
    end else if (sector_rise) begin
      n.sector_count = s.sector_count + 8'h01;
    end
    if (wr_valid && s.wr_ready) begin
      n.pend = wr_data;
      n.pend_full = 1'b1;
      n.took = s.took + 10'h001;
    end
    unique case (s.phase)
      dsf_pkg::DSF_IDLE: begin
        if (cmd_valid && s.cmd_ready) begin
          n.status = '0;
          n.addr = cmd_addr;
          n.phys = map_unit(cmd_addr);
          n.target = interleave(cmd_addr.sector);
          n.writing = cmd_write;
          n.fill = 1'b0;
          n.took = 10'h000;
          n.pend_full = 1'b0;
          if (int'(cmd_addr.unit) >= U0 + U1 ||
              int'(cmd_addr.sector) >= SECTORS_PER_TRACK) begin
            n.status.unit_error = 1'b1;
            n.status.done = 1'b1;
          end else begin
            n.phase = dsf_pkg::DSF_WAIT;
          end
        end
      end
      dsf_pkg::DSF_WAIT: begin
        if ((index_rise || sector_rise) && n.sector_count == s.target) begin
          n.count = 10'h000;
          n.cur_byte = 8'h00;
          if (s.writing) begin
            n.phase = dsf_pkg::DSF_POST;
            n.drive.control_bit[`DSF_CB_WRITE_GATE] = 1'b1;
          end else begin
            n.phase = dsf_pkg::DSF_HSYNC;
            n.drive.control_bit[`DSF_CB_READ_GATE] = 1'b1;
            chk_clear = 1'b1;
          end
        end
      end
      default: begin
        if (index_rise || sector_rise) begin
          // The next pulse ends any sector still in progress
          n = finish(n);
          n.status.sector_overrun = 1'b1;
        end else if (s.writing) begin
          if (tx_take) begin
            if (s.phase == dsf_pkg::DSF_RECOV && c1 == region_len(s.phase)) begin
              n = finish(n);
            end else begin
              if (c1 == region_len(s.phase)) begin
                n.phase = next_phase(s.phase);
                n.count = 10'h000;
              end else begin
                n.count = c1;
              end
              n.cur_byte = 8'h00;
              case (n.phase)
                dsf_pkg::DSF_HSYNC, dsf_pkg::DSF_DSYNC: begin
                  n.cur_byte = SYNC_PATTERN;
                  chk_clear = 1'b1;
                end
                dsf_pkg::DSF_HDR: begin
                  b = hdr_byte(s.addr, n.count[1:0]);
                  n.cur_byte = b;
                  chk_en = 1'b1;
                  chk_byte = b;
                end
                dsf_pkg::DSF_HCHK, dsf_pkg::DSF_DCHK: begin
                  if (n.count == 10'h000) begin
                    n.cur_byte = check[31:24];
                    n.snap = {check[23:0], 8'h00};
                  end else begin
                    n.cur_byte = s.snap[31:24];
                    n.snap = {s.snap[23:0], 8'h00};
                  end
                end
                dsf_pkg::DSF_DATA: begin
                  if (n.pend_full) begin
                    b = n.pend;
                    n.pend_full = 1'b0;
                  end else begin
                    n.fill = 1'b1;
                  end
                  n.cur_byte = b;
                  chk_en = 1'b1;
                  chk_byte = b;
                end
                dsf_pkg::DSF_RECOV: begin
                  // Hold the gate until the second trailing zero has fully left the shifter
                  n.drive.control_bit[`DSF_CB_WRITE_GATE] = (s.phase != dsf_pkg::DSF_RECOV);
                end
                default: begin
                end
              endcase
            end
          end
        end else begin
          case (s.phase)
            dsf_pkg::DSF_HSYNC, dsf_pkg::DSF_DSYNC: begin
              if (sync_found) begin
                n.phase = next_phase(s.phase);
                n.count = 10'h000;
              end
            end
            dsf_pkg::DSF_HDR, dsf_pkg::DSF_HCHK, dsf_pkg::DSF_DATA,
            dsf_pkg::DSF_DCHK: begin
              if (rx_valid) begin
                chk_en = 1'b1;
                chk_byte = rx_byte;
                if (s.phase == dsf_pkg::DSF_HDR) begin
                  n.rx_header = {s.rx_header[23:0], rx_byte};
                end
                if (s.phase == dsf_pkg::DSF_DATA) begin
                  n.rd_data = rx_byte;
                  n.rd_valid = 1'b1;
                end
                if (c1 == region_len(s.phase)) begin
                  n.phase = next_phase(s.phase);
                  n.count = 10'h000;
                end else begin
                  n.count = c1;
                end
              end
            end
            dsf_pkg::DSF_HTRL: begin
              if (check != 32'h00000000) begin
                n = finish(n);
                n.status.header_crc_error = 1'b1;
              end else if (s.rx_header != {s.addr.cylinder, s.addr.track, s.addr.sector}) begin
                n = finish(n);
                n.status.header_mismatch = 1'b1;
              end else begin
                n.phase = dsf_pkg::DSF_DSYNC;
                chk_clear = 1'b1;
              end
            end
            dsf_pkg::DSF_DTRL: begin
              n = finish(n);
              if (check != 32'h00000000) begin
                n.status.data_check = 1'b1;
                n.status.correction_request = 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
      end
    endcase
    // Data-field code mode is selected by the phase the byte belongs to
    chk_mode = (n.phase > dsf_pkg::DSF_HTRL);
    n.status.busy = (n.phase != dsf_pkg::DSF_IDLE);
    n.cmd_ready = (n.phase == dsf_pkg::DSF_IDLE);
    n.wr_ready = n.writing && n.status.busy && !n.pend_full && !n.fill &&
                 (n.took < 10'(`DSF_DATA_BYTES));
    n.drive.write_data = tx_bit & n.drive.control_bit[`DSF_CB_WRITE_GATE];
    n.drive.write_clock = s.sync2.servo_clock;
    n.drive.control_tag = n.status.busy;
    n.drive.control_bit[9:2] = n.status.busy ? drive_command[9:2] : 8'h00;
    // The formatter supplies its own sync byte, so address marks stay off
    n.drive.control_bit[`DSF_CB_ADDRESS_MARK_ENABLE] = 1'b0;
    n.drive.drive_select = n.phys.drive;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.phase <= dsf_pkg::DSF_IDLE;
      s.cmd_ready <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign cmd_ready = s.cmd_ready;
  assign cmd_ready_unused_guard = s.addr;
  assign phys = s.phys;
  assign status = s.status;
  assign wr_ready = s.wr_ready;
  assign rd_data = s.rd_data;
  assign rd_valid = s.rd_valid;
  assign drive_out = s.drive;
endmodule : dsf_formatter

/* File: logic/dsf_serdes.sv */
// Bit serialiser and sync-framed deserialiser for the serial data cable.
// Assumes bit ticks already derived from synchronised drive clocks.
`include "dsf_consts.svh"
module dsf_serdes #(
  parameter logic [7:0] SYNC_PATTERN = `DSF_SYNC_PATTERN
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Transmit
  input wire logic tx_tick,
  input wire logic [7:0] tx_byte,
  output logic tx_bit,
  output logic tx_take,
  // Receive
  input wire logic rx_tick,
  input wire logic rx_bit,
  input wire logic rx_hunt,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic sync_found
);
  dsf_pkg::dsf_serdes_state_type s;
  dsf_pkg::dsf_serdes_state_type n;
  logic [7:0] sh;

  always_comb begin
    n = s;
    n.tx_take = 1'b0;
    n.rx_valid = 1'b0;
    n.sync_found = 1'b0;
    sh = {s.rx_shift[6:0], rx_bit};
    if (tx_tick) begin
      // Loading on the first bit gives the formatter a whole byte time to refill
      if (s.tx_count == 3'h0) begin
        n.tx_bit = tx_byte[7];
        n.tx_shift = {tx_byte[6:0], 1'b0};
        n.tx_take = 1'b1;
      end else begin
        n.tx_bit = s.tx_shift[7];
        n.tx_shift = {s.tx_shift[6:0], 1'b0};
      end
      n.tx_count = s.tx_count + 3'h1;
    end
    if (rx_tick) begin
      n.rx_shift = sh;
      if (rx_hunt) begin
        n.framed = (sh == SYNC_PATTERN);
        n.rx_count = 3'h0;
        n.sync_found = (sh == SYNC_PATTERN);
      end else if (s.framed) begin
        n.rx_count = s.rx_count + 3'h1;
        if (s.rx_count == 3'h7) begin
          n.rx_byte = sh;
          n.rx_valid = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tx_bit = s.tx_bit;
  assign tx_take = s.tx_take;
  assign rx_byte = s.rx_byte;
  assign rx_valid = s.rx_valid;
  assign sync_found = s.sync_found;
endmodule : dsf_serdes

/* File: logic/dsf_unused_marker_none.sv */
// No logic lives in this file.

/* File: testbench/dsf_drive_model.sv */
// Drive model: free servo and read clocks, index and sector pulses, records written bits.
// Assumes the formatter writes only while its write gate bit is high.
module dsf_drive_model (
  // Cables to the controller
  output dsf_pkg::dsf_drive_in_type drive_in,
  input wire dsf_pkg::dsf_drive_out_type drive_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic bits [$];
  int cnt;
  int start;
  initial begin
    drive_in = '0;
    cnt = 0;
    forever begin
      #62.5;
      drive_in.servo_clock = 1'b1;
      drive_in.read_clock = 1'b1;
      // Nothing recorded to play back, so the data line keeps changing
      drive_in.read_data = cnt[0] ^ cnt[2];
      drive_in.index_pulse = (cnt % 9600) < 4;
      // First sector pulse comes 100 ticks after index, so the sector that index opens is short
      drive_in.sector_pulse = (cnt % 4800) >= 100 && (cnt % 4800) < 104;
      #62.5;
      drive_in.servo_clock = 1'b0;
      drive_in.read_clock = 1'b0;
      cnt++;
    end
  end
  always @(negedge drive_out.write_clock) begin
    if (drive_out.control_bit[0]) bits.push_back(drive_out.write_data);
  end
  // Servo tick count at which the write gate came up
  always @(posedge drive_out.control_bit[0]) start = cnt;
endmodule : dsf_drive_model

/* File: testbench/dsf_formatter_props.sv */
// Checker for the sector formatter command, status and drive control ports.
// Assumes it is bound to the formatter top and sees only its ports.
module dsf_formatter_props (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Command and status
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire dsf_pkg::dsf_addr_type cmd_addr,
  input wire dsf_pkg::dsf_status_type status,
  // Data and drive
  input wire logic rd_valid,
  input wire dsf_pkg::dsf_drive_out_type drive_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  a_take_tag: assert property (cmd_valid && cmd_ready && cmd_addr.sector < 8'h23
    |=> status.busy && drive_out.control_tag)
    else $error("command taken without busy and control tag");
  a_busy_refuse: assert property (status.busy |-> !cmd_ready)
    else $error("ready while busy");
  a_bad_sector: assert property (cmd_valid && cmd_ready && cmd_addr.sector >= 8'h23
    |-> ##[1:2] status.done && status.unit_error)
    else $error("bad sector not refused");
  a_done_pulse: assert property (status.done |=> !status.done)
    else $error("done longer than one cycle");
  a_hdr_no_corr: assert property (status.header_crc_error |-> !status.correction_request)
    else $error("correction after header failure");
  a_corr_data: assert property (status.correction_request |-> status.done && status.data_check)
    else $error("correction without data check");
  a_gate_tag: assert property (drive_out.control_bit[0] || drive_out.control_bit[1]
    |-> drive_out.control_tag)
    else $error("gate without control tag");
  a_gate_excl: assert property (!(drive_out.control_bit[0] && drive_out.control_bit[1]))
    else $error("both gates high");
  a_no_rd_write: assert property (drive_out.control_bit[0] |-> !rd_valid)
    else $error("read data during write");
  a_rd_pulse: assert property (rd_valid |=> !rd_valid)
    else $error("read strobe too long");
endmodule : dsf_formatter_props

/* File: testbench/dsf_formatter_test.sv */
// Bench: a refused sector number, then one full sector write checked on the wire.
// Assumes the drive model records the serial write stream.
`include "dsf_consts.svh"
module dsf_formatter_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, cmd_valid, cmd_write, wr_valid, cmd_ready, wr_ready, rd_valid;
  logic [9:0] drive_command;
  logic [7:0] wr_data, rd_data, trk;
  logic [7:0] data [0:511];
  logic [15:0] cyl;
  dsf_pkg::dsf_addr_type cmd_addr;
  dsf_pkg::dsf_phys_type phys;
  dsf_pkg::dsf_status_type status;
  dsf_pkg::dsf_drive_in_type drive_in;
  dsf_pkg::dsf_drive_out_type drive_out;
  int errors, compares, i, n, p;
  dsf_formatter u_dut (.clk, .resetn, .cmd_valid, .cmd_write, .cmd_addr, .drive_command,
    .cmd_ready_unused_guard(), .cmd_ready, .phys, .status, .wr_data, .wr_valid, .wr_ready,
    .rd_data, .rd_valid, .drive_in, .drive_out);
  dsf_drive_model u_drive (.drive_in, .drive_out);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want) begin
      errors++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  function automatic logic [7:0] byte_at(input int b);
    for (int k = 0; k < 8; k++) byte_at = {byte_at[6:0], u_drive.bits[p + b * 8 + k]};
  endfunction : byte_at
  task automatic send(input logic [2:0] u, input logic [7:0] s, input logic w);
    cmd_addr = {u, cyl, trk, s};
    cmd_write = w;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask : send
  task automatic wait_done();
    for (int k = 0; k < 70000 && status.done !== 1'b1; k++) @(negedge clk);
    check(status.done, 1'b1);
  endtask : wait_done
  task automatic final_report();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  initial begin
    {errors, compares, cmd_valid, cmd_write, wr_valid, wr_data, cyl, trk} = '0;
    cmd_addr = '0;
    drive_command = '0;
    resetn = 1'b0;
    void'($urandom(41));
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    send(3'h1, 8'h28, 1'b0);
    wait_done();
    check(status.unit_error, 1'b1);
    $display("test bad_sector done");
    cyl = 16'($urandom % 100);
    trk = 8'($urandom % 19);
    drive_command = 10'($urandom) & 10'h3DC;
    n = 16 + $urandom % 200;
    for (i = 0; i < 512; i++) data[i] = i < n ? 8'($urandom) : 8'h00;
    // Logical sector 12 lands on the first sector pulse after index
    send(3'h5, 8'h0C, 1'b1);
    check(phys.drive, 1'b1);
    check({drive_out.control_tag, drive_out.control_bit[9:2]}, {1'b1, drive_command[9:2]});
    // Feeding stops early so the rest of the field must go out as zeros
    for (i = 0; i < n; i++) begin
      wr_data = data[i];
      wr_valid = 1'b1;
      // Ready is settled at the falling edge; the next rising edge takes the byte
      while (wr_ready !== 1'b1) @(negedge clk);
      @(negedge clk);
    end
    wr_valid = 1'b0;
    wait_done();
    check(u_drive.start >= 100 && u_drive.start < 104, 1'b1);
    p = 0;
    while (p < 200 && byte_at(0) !== `DSF_SYNC_PATTERN) p++;
    check(p >= 136, 1'b1);
    check({byte_at(1), byte_at(2)}, cyl);
    check({byte_at(3), byte_at(4)}, {trk, 8'h0C});
    for (i = 9; i < 24; i++) check(byte_at(i), 8'h00);
    check(byte_at(24), `DSF_SYNC_PATTERN);
    for (i = 0; i < 512; i++) check(byte_at(25 + i), data[i]);
    check({byte_at(541), byte_at(542)}, 16'h0000);
    $display("test sector_write done");
    final_report();
  end
  initial begin
    #800000;
    errors++;
    final_report();
  end
endmodule : dsf_formatter_test
bind dsf_formatter dsf_formatter_props u_props (.clk, .resetn, .cmd_valid, .cmd_ready,
  .cmd_addr, .status, .rd_valid, .drive_out);
